// file: src/drs_pkg.sv
package drs_pkg;
  localparam int DRS_NUM_REGIONS = 20;
  localparam int DRS_ADDR_W = 12;
  localparam int DRS_REGION_W = 5;
  localparam logic [3:0] DRS_OFF_BASE = 4'h0;
  localparam logic [3:0] DRS_OFF_START = 4'h4;
  localparam logic [3:0] DRS_OFF_SETUP = 4'h8;
  localparam logic [3:0] DRS_OFF_SPAN = 4'h0;
  localparam int DRS_START_W = 19;
  localparam int DRS_DSIZE_LSB = 16;
  localparam int DRS_DSIZE_W = 13;
  localparam int DRS_RSIZE_LSB = 0;
  localparam int DRS_RSIZE_W = 4;
  localparam int DRS_DESC_UNIT_SHIFT = 4;
  localparam int DRS_RSIZE_BIAS = 5;
  localparam logic [31:0] DRS_RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] DRS_START_MASK = 32'h0007_ffff;
  localparam logic [31:0] DRS_SETUP_MASK = 32'h1fff_000f;
  localparam int DRS_LOOKUP_LATENCY = 2;
endpackage

// file: src/drs_region_mem.sv
`timescale 1ns/1ps
`default_nettype none
module drs_region_mem #(
  parameter int DEPTH = 20,
  parameter int AW = 5
) (
  // Clock, reset and clock enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [31:0] wr_data_in,
  // Read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [31:0] rd_data_out
);
  logic [31:0] mem_r [DEPTH];

  // Flops, not RAM: all words must clear on reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= 32'h0000_0000;
      end
    end else if (ce_in && wr_en_in && (int'(wr_addr_in) < DEPTH)) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 32'h0000_0000;
    end else if (ce_in) begin
      rd_data_out <= (int'(rd_addr_in) < DEPTH) ? mem_r[rd_addr_in]
                                                : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// file: src/drs_setup.sv
// Notes on behaviour
// - Each region has a 32-bit read/write base address.
// - Each region has a 19-bit first linking-RAM index.
// - Descriptor size is 16 bytes times (code plus one).
// - Region holds two to the power (5 plus code) descriptors.
// - Unused bits of index and setup words read zero, writes dropped.
// - Words at 0, 4, 8 inside a 16-byte block at 16 times region.
`timescale 1ns/1ps
`default_nettype none
module drs_setup
  import drs_pkg::*;
#(
  parameter int NUM_REGIONS = DRS_NUM_REGIONS
) (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [DRS_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Lookup request
  input wire logic lk_req_in,
  input wire logic [DRS_REGION_W-1:0] lk_region_in,
  input wire logic [DRS_START_W-1:0] lk_index_in,
  // Lookup answer
  output logic lk_valid_out,
  output logic lk_hit_out,
  output logic [31:0] lk_addr_out,
  output logic [DRS_START_W-1:0] lk_link_out,
  output logic [17:0] lk_desc_bytes_out,
  output logic [20:0] lk_region_count_out
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    DRS_SEL_BASE = 2'b00,
    DRS_SEL_START = 2'b01,
    DRS_SEL_SETUP = 2'b10,
    DRS_SEL_NONE = 2'b11
  } drs_sel_t;

  function automatic drs_sel_t drs_decode(input logic [3:0] off);
    if (off == DRS_OFF_BASE) begin
      return DRS_SEL_BASE;
    end else if (off == DRS_OFF_START) begin
      return DRS_SEL_START;
    end else if (off == DRS_OFF_SETUP) begin
      return DRS_SEL_SETUP;
    end else begin
      return DRS_SEL_NONE;
    end
  endfunction

  function automatic logic [17:0] drs_desc_bytes(input logic [31:0] s);
    logic [17:0] c;
    c = {5'h00, s[DRS_DSIZE_LSB +: DRS_DSIZE_W]} + 18'h00001;
    return c << DRS_DESC_UNIT_SHIFT;
  endfunction

  function automatic logic [20:0] drs_region_count(input logic [31:0] s);
    logic [4:0] e;
    e = {1'b0, s[DRS_RSIZE_LSB +: DRS_RSIZE_W]} + 5'(DRS_RSIZE_BIAS);
    return 21'h000001 << e;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: region in upper address, word in low nibble
  drs_sel_t bus_sel;
  logic [DRS_REGION_W-1:0] bus_region;
  logic bus_in_range;
  logic [31:0] wr_masked;
  logic wr_base, wr_start, wr_setup;

  assign bus_sel = drs_decode(reg_addr_in[3:0]);
  assign bus_region = reg_addr_in[4 +: DRS_REGION_W];
  assign bus_in_range =
    (reg_addr_in[DRS_ADDR_W-1:4] < (DRS_ADDR_W-4)'(NUM_REGIONS));
  assign wr_base = reg_wr_in && bus_in_range && (bus_sel == DRS_SEL_BASE);
  assign wr_start = reg_wr_in && bus_in_range && (bus_sel == DRS_SEL_START);
  assign wr_setup = reg_wr_in && bus_in_range && (bus_sel == DRS_SEL_SETUP);

  always_comb begin
    wr_masked = reg_wdata_in;
    if (bus_sel == DRS_SEL_START) begin
      wr_masked = reg_wdata_in & DRS_START_MASK;
    end else if (bus_sel == DRS_SEL_SETUP) begin
      wr_masked = reg_wdata_in & DRS_SETUP_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Three banks; bus read and lookup share ports, lookup reads when idle
  logic [DRS_REGION_W-1:0] rd_region;
  logic [31:0] base_q, start_q, setup_q;
  logic bus_rd_busy;

  assign bus_rd_busy = reg_rd_in;
  assign rd_region = bus_rd_busy ? bus_region : lk_region_in;

  drs_region_mem #(.DEPTH(NUM_REGIONS), .AW(DRS_REGION_W)) u_base (
    .clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(clk_en_in),
    .wr_en_in(wr_base), .wr_addr_in(bus_region),
    .wr_data_in(wr_masked), .rd_addr_in(rd_region), .rd_data_out(base_q)
  );
  drs_region_mem #(.DEPTH(NUM_REGIONS), .AW(DRS_REGION_W)) u_start (
    .clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(clk_en_in),
    .wr_en_in(wr_start), .wr_addr_in(bus_region),
    .wr_data_in(wr_masked), .rd_addr_in(rd_region), .rd_data_out(start_q)
  );
  drs_region_mem #(.DEPTH(NUM_REGIONS), .AW(DRS_REGION_W)) u_setup (
    .clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(clk_en_in),
    .wr_en_in(wr_setup), .wr_addr_in(bus_region),
    .wr_data_in(wr_masked), .rd_addr_in(rd_region), .rd_data_out(setup_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read answer one cycle after the strobe
  logic rd_pend_r;
  drs_sel_t rd_sel_r;
  logic rd_ok_r;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pend_r <= 1'b0;
      rd_sel_r <= DRS_SEL_NONE;
      rd_ok_r <= 1'b0;
    end else if (clk_en_in) begin
      rd_pend_r <= reg_rd_in;
      rd_sel_r <= bus_sel;
      rd_ok_r <= bus_in_range;
    end
  end

  always_comb begin
    reg_rdata_out = 32'h0000_0000;
    if (rd_pend_r && rd_ok_r) begin
      case (rd_sel_r)
        DRS_SEL_BASE: reg_rdata_out = base_q;
        DRS_SEL_START: reg_rdata_out = start_q & DRS_START_MASK;
        DRS_SEL_SETUP: reg_rdata_out = setup_q & DRS_SETUP_MASK;
        default: reg_rdata_out = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lookup: stage 1 reads banks, stage 2 computes outputs
  logic lk_s1_r;
  logic [DRS_START_W-1:0] lk_idx_r;
  logic lk_go;

  // A bus read steals the bank port; the lookup is dropped that cycle
  assign lk_go = lk_req_in && !bus_rd_busy;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk_s1_r <= 1'b0;
      lk_idx_r <= '0;
    end else if (clk_en_in) begin
      lk_s1_r <= lk_go;
      lk_idx_r <= lk_index_in;
    end
  end

  logic [DRS_START_W-1:0] lk_start;
  logic [DRS_START_W-1:0] lk_off;
  logic [17:0] lk_bytes;
  logic [20:0] lk_count;
  logic lk_hit_nxt;
  logic [31:0] lk_addr_nxt;
  logic [50:0] lk_prod;

  always_comb begin
    lk_start = start_q[DRS_START_W-1:0];
    lk_off = lk_idx_r - lk_start;
    lk_bytes = drs_desc_bytes(setup_q);
    lk_count = drs_region_count(setup_q);
    lk_hit_nxt = (lk_idx_r >= lk_start) &&
                 ({2'b00, lk_off} < lk_count) && (base_q != 32'h0000_0000);
    lk_prod = 51'(lk_off) * 51'(lk_bytes);
    lk_addr_nxt = base_q + lk_prod[31:0];
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk_valid_out <= 1'b0;
      lk_hit_out <= 1'b0;
      lk_addr_out <= 32'h0000_0000;
      lk_link_out <= '0;
      lk_desc_bytes_out <= '0;
      lk_region_count_out <= '0;
    end else if (clk_en_in) begin
      lk_valid_out <= lk_s1_r;
      lk_hit_out <= lk_s1_r && lk_hit_nxt;
      lk_addr_out <= lk_addr_nxt;
      lk_link_out <= lk_idx_r;
      lk_desc_bytes_out <= lk_bytes;
      lk_region_count_out <= lk_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic [DRS_REGION_W-1:0] p_reg_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      p_reg_r <= '0;
    end else begin
      p_reg_r <= bus_region;
    end
  end

  property p_rd_zero_unmapped;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_rd_in && clk_en_in && bus_sel == DRS_SEL_NONE)
        |=> reg_rdata_out == 32'h0000_0000;
  endproperty
  a_rd_zero_unmapped: assert property (p_rd_zero_unmapped)
    else $error("unmapped offset read nonzero");

  property p_start_resv;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (rd_pend_r && rd_sel_r == DRS_SEL_START) |->
        (start_q[31:19] == '0 && reg_rdata_out[31:19] == '0);
  endproperty
  a_start_resv: assert property (p_start_resv)
    else $error("start index reserved bits nonzero");

  property p_setup_resv;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (rd_pend_r && rd_sel_r == DRS_SEL_SETUP)
        |-> (setup_q[31:29] == '0 && setup_q[15:4] == '0 &&
             reg_rdata_out[31:29] == '0 && reg_rdata_out[15:4] == '0);
  endproperty
  a_setup_resv: assert property (p_setup_resv)
    else $error("setup reserved bits nonzero");

  property p_base_wr_rd;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (clk_en_in && wr_base) ##1
      (clk_en_in && reg_rd_in && bus_sel == DRS_SEL_BASE && bus_region ==
       p_reg_r && !reg_wr_in) |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_base_wr_rd: assert property (p_base_wr_rd)
    else $error("base readback mismatch");

  property p_lk_latency;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (clk_en_in && lk_go) ##1 clk_en_in |=> lk_valid_out;
  endproperty
  a_lk_latency: assert property (p_lk_latency)
    else $error("lookup answer late");

  property p_lk_bytes;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      lk_valid_out |-> (lk_desc_bytes_out[3:0] == 4'h0 &&
                        lk_desc_bytes_out != '0);
  endproperty
  a_lk_bytes: assert property (p_lk_bytes)
    else $error("descriptor size not multiple of 16");

  property p_lk_count;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      lk_valid_out |-> (lk_region_count_out >= 21'h000020 &&
                        $onehot(lk_region_count_out));
  endproperty
  a_lk_count: assert property (p_lk_count)
    else $error("region count not power of two from 32");

  property p_lk_link;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (clk_en_in && lk_go) ##1 clk_en_in |=>
        lk_link_out == $past(lk_index_in, 2);
  endproperty
  a_lk_link: assert property (p_lk_link)
    else $error("link index not carried");

  c_write_base: cover property (@(posedge core_clk_in) wr_base);
  c_read_setup: cover property (@(posedge core_clk_in)
    rd_pend_r && rd_sel_r == DRS_SEL_SETUP);
  c_lookup_hit: cover property (@(posedge core_clk_in) lk_hit_out);
endmodule
`default_nettype wire

// file: verification/drs_setup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drs_setup_tb;
  import drs_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [11:0] reg_addr_in = 12'h000;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic lk_req_in = 1'b0;
  logic [4:0] lk_region_in = 5'h00;
  logic [18:0] lk_index_in = 19'h0;
  logic [31:0] reg_rdata_out, lk_addr_out;
  logic lk_valid_out, lk_hit_out;
  logic [18:0] lk_link_out;
  logic [17:0] lk_desc_bytes_out;
  logic [20:0] lk_region_count_out;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] m [0:19][0:2];
  ////////////////////////////////////////////////////////////////////////
  drs_setup #(.NUM_REGIONS(20)) dut_u (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .lk_req_in(lk_req_in),
    .lk_region_in(lk_region_in), .lk_index_in(lk_index_in),
    .lk_valid_out(lk_valid_out), .lk_hit_out(lk_hit_out),
    .lk_addr_out(lk_addr_out), .lk_link_out(lk_link_out),
    .lk_desc_bytes_out(lk_desc_bytes_out),
    .lk_region_count_out(lk_region_count_out)
  );
  always #12.5 core_clk_in = ~core_clk_in;
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clr();
    foreach (m[r, o]) m[r][o] = 32'h0;
  endtask
  // Model of the bank: masks applied on write, unmapped places read zero
  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    if (a[11:9] != 3'h0 || a[8:4] > 5'd19 || a[3:0] > 4'h8 || a[1:0] != 0)
      return 32'h0;
    return m[a[8:4]][a[3:2]];
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] mk [0:2];
    mk = '{32'hffff_ffff, DRS_START_MASK, DRS_SETUP_MASK};
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    if (clk_en_in && exp_rd(a) !== 32'h0 || clk_en_in && a < 12'h140 &&
        a[3:0] inside {4'h0, 4'h4, 4'h8})
      m[a[8:4]][a[3:2]] = d & mk[a[3:2]];
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    chk("rdata", reg_rdata_out, exp_rd(a));
  endtask
  // Base write then read of the same word on the very next strobe
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    if (a < 12'h140 && a[3:0] == 4'h0) m[a[8:4]][0] = d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    chk("wr_rd", reg_rdata_out, exp_rd(a));
  endtask
  // Lookup, optionally colliding with a bus read of the same region
  task automatic lk(input int r, input int i, input bit col);
    logic [18:0] idx, st;
    logic [31:0] by, cn;
    bit hit, vld;
    idx = 19'(i);
    st = m[r][1][18:0];
    by = 32'(16 * (int'(m[r][2][28:16]) + 1));
    cn = 32'h1 << (5 + m[r][2][3:0]);
    hit = m[r][0] != 0 && idx >= st && 32'(idx) < 32'(st) + cn;
    vld = !col && clk_en_in;
    @(posedge core_clk_in);
    lk_req_in <= 1'b1;
    lk_region_in <= 5'(r);
    lk_index_in <= idx;
    reg_addr_in <= 12'(r * 16 + 4);
    reg_rd_in <= col;
    @(posedge core_clk_in);
    lk_req_in <= 1'b0;
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    chk("valid_early", 32'(lk_valid_out), 32'h0);
    if (col) chk("rd_col", reg_rdata_out, m[r][1]);
    repeat (DRS_LOOKUP_LATENCY - 1) @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk("valid", 32'(lk_valid_out), 32'(vld));
    if (vld) begin
      chk("hit", 32'(lk_hit_out), 32'(hit));
      chk("link", 32'(lk_link_out), 32'(idx));
      chk("bytes", 32'(lk_desc_bytes_out), by);
      chk("count", 32'(lk_region_count_out), cn);
      if (hit) begin
        chk("addr", lk_addr_out, m[r][0] + 32'(idx - st) * by);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    n_errors++;
    close_out();
  end
  initial begin
    logic [31:0] d;
    int st, cn;
    clr();
    void'($urandom(32'hf031));
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a < 20 * 16; a += 4) rd(12'(a));
    for (int r = 0; r < 32; r++) begin
      for (int o = 0; o < 16; o += 4) begin
        d = $urandom;
        if (o == 8) d[3:0] = 4'(r % 16);
        if (o == 8 && r < 3) d[28:16] = (r == 0) ? 13'h0 :
                                        (r == 1) ? 13'h3 : 13'h1fff;
        if (o == 4) d[18:14] = 5'(r);
        if (o == 0) d[31:27] = 5'(r);
        if (o == 0) d[3:0] = 4'h0;
        if (o == 0 && r == 5) d = 32'h0;
        wr(12'(r * 16 + o), d);
      end
    end
    for (int a = 0; a < 32 * 16; a += 4) rd(12'(a));
    for (int r = 0; r < 20; r++) begin
      st = int'(m[r][1][18:0]);
      cn = 1 << (5 + m[r][2][3:0]);
      lk(r, st + int'($urandom % cn), 1'b0);
      lk(r, st, 1'b0);
      if (st > 0) lk(r, st - 1, 1'b0);
      if (st + cn < (1 << 19)) lk(r, st + cn, 1'b0);
      if (st + cn - 1 < (1 << 19)) lk(r, st + cn - 1, 1'b0);
    end
    for (int r = 6; r < 9; r++) begin
      d = (32'(r) << 27) | ($urandom & 32'h07ff_fff0);
      wr_rd(12'(r * 16), d);
    end
    lk(3, int'(m[3][1]), 1'b1);
    // Disable by clearing base first, re-enable with base written last
    wr(12'h040, 32'h0);
    lk(4, int'(m[4][1]), 1'b0);
    wr(12'h048, 32'h0003_0002);
    wr(12'h040, 32'h2000_0040);
    lk(4, int'(m[4][1][18:0]) + 5, 1'b0);
    // Frozen enable: bus write and lookup must both be dropped
    @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    wr(12'h010, 32'h5);
    lk(1, int'(m[1][1]), 1'b0);
    @(posedge core_clk_in);
    clk_en_in <= 1'b1;
    rd(12'h010);
    // Second reset mid-run clears the whole bank
    @(posedge core_clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    clr();
    for (int a = 0; a < 20 * 16; a += 20) rd(12'(a));
    lk(2, 0, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
